// ==== rop_consts.vh ====
// Constants for the ring-oscillator PLL configuration block.
// Assumes a 16-bit register port with 16-bit addresses on the core clock.
`ifndef ROP_CONSTS_VH
`define ROP_CONSTS_VH

`define ROP_ADDR_W 16
`define ROP_DATA_W 16

`define ROP_ADDR_CFG_LOW 16'hF980
`define ROP_ADDR_CFG_HIGH 16'hF984
`define ROP_ADDR_STATUS 16'hF98C

`define ROP_RST_CFG_LOW 16'h0141
`define ROP_RST_CFG_HIGH 16'h0000
`define ROP_RST_STATUS 16'h0000

`define ROP_LO_FRAC_MSB 15
`define ROP_LO_FRAC_LSB 9
`define ROP_LO_INT_MSB 8
`define ROP_LO_INT_LSB 2
`define ROP_LO_LOCK_BIT 1
`define ROP_LO_RST_BIT 0

`define ROP_HI_BUFOUT_BIT 15
`define ROP_HI_BYPASS_BIT 14
`define ROP_HI_FRAC_MSB 13
`define ROP_HI_FRAC_LSB 0

`define ROP_ST_LOST_BIT 0
`define ROP_ST_LIVE_BIT 1

`define ROP_FRAC_W 21
`define ROP_FRAC_LO_W 7
`define ROP_FRAC_HI_W 14
`define ROP_INT_W 7

`define ROP_RST_FRAC_LO 7'h00
`define ROP_RST_INT 7'h50
`define ROP_RST_RSTN 1'h1
`define ROP_RST_FRAC_HI 14'h0000
`define ROP_RST_BYPASS 1'h0
`define ROP_RST_BUFOUT 1'h0

`endif

// ==== rop_field_reg.v ====
// One writable configuration field with a hardware-only reset value.
// Assumes the write enable is a single-cycle strobe on the core clock.
`timescale 1ns/1ps
module rop_field_reg #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'h0}}
) (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire wr_en_in,
  input wire [WIDTH-1:0] wr_data_in,
  output wire [WIDTH-1:0] value_out
);
  reg [WIDTH-1:0] value_r;

  // Only the hardware reset reaches this flop; software resets do not.
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      value_r <= RESET_VAL;
    end else if (wr_en_in) begin
      value_r <= wr_data_in;
    end
  end

  assign value_out = value_r;
endmodule

// ==== rop_pll_cfg.v ====
// Register block that configures the ring-oscillator PLL of the clock generation unit.
// Assumes a one-cycle read/write strobe port on the core clock and an analog PLL
// whose lock indication is asynchronous to that clock.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "rop_consts.vh"

// Overview of operation
// - Both configuration registers ignore software resets; only hardware reset restores them.
// - Low register bits 15:9 drive fractional divider bits 6:0.
// - High register bits 13:0 drive fractional divider bits 20:7.
// - Low register bits 8:2 drive the 7-bit integer divider unchanged.
// - Low register bit 1 is read-only lock state, 0 unlocked, 1 locked.
// - Low register bit 0 is active-low PLL reset; 0 holds reset.
// - High register bit 14 bypasses the PLL when 1; default 0.
// - High register bit 15 enables the reference buffered output; default 0.
module rop_pll_cfg (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire [15:0] addr_in,
  input wire [15:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  output wire [15:0] rd_data_out,
  input wire pll_lock_in,
  output wire [20:0] pll_frac_div_out,
  output wire [6:0] pll_int_div_out,
  output wire pll_rst_n_out,
  output wire pll_bypass_sel_out,
  output wire ref_buffer_out_en_out
);
  wire sel_low;
  wire sel_high;
  wire sel_status;
  wire wr_low;
  wire wr_high;
  wire wr_status;
  wire [6:0] frac_lo;
  wire [13:0] frac_hi;
  wire [6:0] int_div;
  wire rst_n;
  wire bypass;
  wire bufout;
  wire lock_sync;
  reg lock_prev_r;
  reg lock_lost_r;
  reg lock_lost_nxt;
  reg [15:0] rd_data_r;
  reg [15:0] rd_data_nxt;
  wire [15:0] cfg_low_view;
  wire [15:0] cfg_high_view;
  wire [15:0] status_view;

  assign sel_low = (addr_in == `ROP_ADDR_CFG_LOW);
  assign sel_high = (addr_in == `ROP_ADDR_CFG_HIGH);
  assign sel_status = (addr_in == `ROP_ADDR_STATUS);
  assign wr_low = wr_en_in & sel_low;
  assign wr_high = wr_en_in & sel_high;
  assign wr_status = wr_en_in & sel_status;

  // Low configuration register fields.
  rop_field_reg #(
    .WIDTH(`ROP_FRAC_LO_W),
    .RESET_VAL(`ROP_RST_FRAC_LO)
  ) u_frac_lo (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .wr_en_in(wr_low),
    .wr_data_in(wr_data_in[`ROP_LO_FRAC_MSB:`ROP_LO_FRAC_LSB]),
    .value_out(frac_lo)
  );

  rop_field_reg #(
    .WIDTH(`ROP_INT_W),
    .RESET_VAL(`ROP_RST_INT)
  ) u_int_div (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .wr_en_in(wr_low),
    .wr_data_in(wr_data_in[`ROP_LO_INT_MSB:`ROP_LO_INT_LSB]),
    .value_out(int_div)
  );

  rop_field_reg #(
    .WIDTH(1),
    .RESET_VAL(`ROP_RST_RSTN)
  ) u_rst_n (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .wr_en_in(wr_low),
    .wr_data_in(wr_data_in[`ROP_LO_RST_BIT]),
    .value_out(rst_n)
  );

  // High configuration register fields.
  rop_field_reg #(
    .WIDTH(`ROP_FRAC_HI_W),
    .RESET_VAL(`ROP_RST_FRAC_HI)
  ) u_frac_hi (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .wr_en_in(wr_high),
    .wr_data_in(wr_data_in[`ROP_HI_FRAC_MSB:`ROP_HI_FRAC_LSB]),
    .value_out(frac_hi)
  );

  rop_field_reg #(
    .WIDTH(1),
    .RESET_VAL(`ROP_RST_BYPASS)
  ) u_bypass (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .wr_en_in(wr_high),
    .wr_data_in(wr_data_in[`ROP_HI_BYPASS_BIT]),
    .value_out(bypass)
  );

  rop_field_reg #(
    .WIDTH(1),
    .RESET_VAL(`ROP_RST_BUFOUT)
  ) u_bufout (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .wr_en_in(wr_high),
    .wr_data_in(wr_data_in[`ROP_HI_BUFOUT_BIT]),
    .value_out(bufout)
  );

  // The analog lock flag can toggle at any moment relative to the core clock.
  rop_sync2 u_lock_sync (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .async_in(pll_lock_in),
    .sync_out(lock_sync)
  );

  // A lock drop while the PLL runs is easy to miss by polling, so it is kept sticky.
  // A new drop in the same cycle as a write-one clear keeps the flag set.
  always @* begin
    lock_lost_nxt = lock_lost_r;
    if (wr_status && wr_data_in[`ROP_ST_LOST_BIT]) begin
      lock_lost_nxt = 1'h0;
    end
    if (lock_prev_r && !lock_sync && rst_n) begin
      lock_lost_nxt = 1'h1;
    end
  end

  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_prev_r <= 1'h0;
      lock_lost_r <= 1'h0;
    end else begin
      lock_prev_r <= lock_sync;
      lock_lost_r <= lock_lost_nxt;
    end
  end

  assign cfg_low_view = {frac_lo, int_div, lock_sync, rst_n};
  assign cfg_high_view = {bufout, bypass, frac_hi};
  assign status_view = {14'h0000, lock_sync, lock_lost_r};

  // Read data stands only in the cycle after the strobe; unmapped reads return zero.
  always @* begin
    rd_data_nxt = 16'h0000;
    if (rd_en_in) begin
      if (sel_low) begin
        rd_data_nxt = cfg_low_view;
      end else if (sel_high) begin
        rd_data_nxt = cfg_high_view;
      end else if (sel_status) begin
        rd_data_nxt = status_view;
      end else begin
        rd_data_nxt = 16'h0000;
      end
    end
  end

  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_r <= 16'h0000;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data_out = rd_data_r;
  assign pll_frac_div_out = {frac_hi, frac_lo};
  assign pll_int_div_out = int_div;
  assign pll_rst_n_out = rst_n;
  assign pll_bypass_sel_out = bypass;
  assign ref_buffer_out_en_out = bufout;
endmodule

// ==== rop_pll_cfg_props.sv ====
// Assertions for the ring-oscillator PLL configuration block.
// Assumes the one-cycle strobe register port and a lock level from the analog PLL.
`timescale 1ns/1ps
module rop_pll_cfg_props (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire [15:0] addr_in,
  input wire [15:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [15:0] rd_data_out,
  input wire pll_lock_in,
  input wire [20:0] pll_frac_div_out,
  input wire [6:0] pll_int_div_out,
  input wire pll_rst_n_out,
  input wire pll_bypass_sel_out,
  input wire ref_buffer_out_en_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  wire wl = wr_en_in && addr_in == 16'hF980;
  wire wh = wr_en_in && addr_in == 16'hF984;
  wire rl = rd_en_in && addr_in == 16'hF980;
  a_frac_low_map: assert property (wl |=> pll_frac_div_out[6:0] == $past(wr_data_in[15:9]))
    else $error("low fraction field wrong");
  a_frac_high_map: assert property (wh |=> pll_frac_div_out[20:7] == $past(wr_data_in[13:0]))
    else $error("high fraction field wrong");
  a_int_div_map: assert property (wl |=> pll_int_div_out == $past(wr_data_in[8:2]))
    else $error("integer divider wrong");
  a_pll_rst_ctrl: assert property (wl |=> pll_rst_n_out == $past(wr_data_in[0]))
    else $error("pll reset control wrong");
  a_bypass_map: assert property (wh |=> pll_bypass_sel_out == $past(wr_data_in[14]))
    else $error("bypass select wrong");
  a_bufout_map: assert property (wh |=> ref_buffer_out_en_out == $past(wr_data_in[15]))
    else $error("buffered output enable wrong");
  a_cfg_hold: assert property (!(wl || wh) |=> $stable({pll_frac_div_out,
    pll_int_div_out, pll_rst_n_out, pll_bypass_sel_out, ref_buffer_out_en_out}))
    else $error("configuration changed without a write");
  a_read_idle: assert property (!rd_en_in |=> rd_data_out == 16'h0000)
    else $error("read data outside read cycle");
  a_lock_readback: assert property (rl && $past(nrst_in, 2) &&
    $past(pll_lock_in) == pll_lock_in && $past(pll_lock_in, 2) == pll_lock_in
    |=> rd_data_out[1] == $past(pll_lock_in))
    else $error("lock bit readback wrong");
  cover property (wl ##1 !pll_rst_n_out);
  cover property (wh ##1 pll_bypass_sel_out);
  cover property (rl && pll_lock_in ##1 rd_data_out[1]);
  cover property (rd_en_in && addr_in == 16'hF98C ##1 rd_data_out[0]);
endmodule
bind rop_pll_cfg rop_pll_cfg_props chk_u (.sys_clk_in, .nrst_in, .addr_in, .wr_data_in,
  .wr_en_in, .rd_en_in, .rd_data_out, .pll_lock_in, .pll_frac_div_out, .pll_int_div_out,
  .pll_rst_n_out, .pll_bypass_sel_out, .ref_buffer_out_en_out);

// ==== rop_sync2.v ====
// Two-flop synchroniser for one level from outside the core clock domain.
// Assumes the input is a slowly changing level, not a pulse.
`timescale 1ns/1ps
module rop_sync2 (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire async_in,
  output wire sync_out
);
  reg meta_r;
  reg sync_r;

  // The first stage feeds only the second stage.
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_r <= 1'h0;
      sync_r <= 1'h0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule

// ==== testbench.sv ====
// Self-checking bench for the ring-oscillator PLL configuration block.
// Assumes the strobe register port; the bench drives the lock input itself.
`timescale 1ns/1ps
module testbench;
  logic sys_clk_in = 0, nrst_in = 0, wr_en_in = 0, rd_en_in = 0, pll_lock_in = 0;
  logic [15:0] addr_in = 16'h0000, wr_data_in = 16'h0000;
  wire [15:0] rd_data_out;
  wire [20:0] frac;
  wire [6:0] idiv;
  wire rstn, bp, bo;
  int miscompares = 0, check_count = 0;
  rop_pll_cfg dut_u (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .pll_lock_in(pll_lock_in), .pll_frac_div_out(frac),
    .pll_int_div_out(idiv), .pll_rst_n_out(rstn), .pll_bypass_sel_out(bp),
    .ref_buffer_out_en_out(bo));
  initial begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  task cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask
  // Expected pin view worked out from the two register images.
  function logic [31:0] ev(input logic [15:0] lo, input logic [15:0] hi);
    ev = {1'b0, hi[13:0], lo[15:9], lo[8:2], lo[0], hi[14], hi[15]};
  endfunction
  task ck(input logic [31:0] e);
    #1 cmp({1'b0, frac, idiv, rstn, bp, bo}, e);
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    wr_en_in <= 1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge sys_clk_in);
    wr_en_in <= 0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge sys_clk_in);
    rd_en_in <= 1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_en_in <= 0;
    #1 cmp({16'h0000, rd_data_out}, {16'h0000, e});
  endtask
  task hw_rst;
    @(posedge sys_clk_in);
    nrst_in <= 0;
    repeat (2) @(posedge sys_clk_in);
    nrst_in <= 1;
  endtask
  task final_report;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_in);
    nrst_in <= 1;
    ck(ev(16'h0141, 16'h0000));
    rd(16'hF980, 16'h0141);
    rd(16'hF984, 16'h0000);
    $display("test reset values done");
    wr(16'hF980, 16'hFFFF);
    ck(ev(16'hFFFF, 16'h0000));
    wr(16'hF984, 16'hC001);
    ck(ev(16'hFFFF, 16'hC001));
    rd(16'hF980, 16'hFFFD);
    rd(16'hF984, 16'hC001);
    wr(16'hF980, 16'h5A52);
    ck(ev(16'h5A52, 16'hC001));
    wr(16'hF990, 16'hFFFF);
    ck(ev(16'h5A52, 16'hC001));
    rd(16'hF990, 16'h0000);
    $display("test field mapping done");
    @(posedge sys_clk_in);
    pll_lock_in <= 1;
    repeat (3) @(posedge sys_clk_in);
    rd(16'hF980, 16'h5A52);
    @(posedge sys_clk_in);
    pll_lock_in <= 0;
    repeat (3) @(posedge sys_clk_in);
    rd(16'hF980, 16'h5A50);
    rd(16'hF98C, 16'h0000);
    $display("test lock status done");
    wr(16'hF980, 16'h5A53);
    @(posedge sys_clk_in);
    pll_lock_in <= 1;
    repeat (3) @(posedge sys_clk_in);
    rd(16'hF98C, 16'h0002);
    @(posedge sys_clk_in);
    pll_lock_in <= 0;
    repeat (3) @(posedge sys_clk_in);
    rd(16'hF98C, 16'h0001);
    wr(16'hF98C, 16'h0001);
    rd(16'hF98C, 16'h0000);
    $display("test lock loss flag done");
    hw_rst;
    ck(ev(16'h0141, 16'h0000));
    rd(16'hF980, 16'h0141);
    $display("test hardware reset done");
    final_report;
  end
endmodule
